/* tb.sv */
// Self-checking testbench for the virtualization register bank.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import vsp_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic core_clk, resetn, virt_implemented, supervisor_priv, clk_en;
	vsp_sr_req_type sr_req;
	vsp_sr_rsp_type sr_rsp, r;
	vsp_perf_ev_type perf_ev;
	vsp_irq_type irq_state;
	logic virt_enable, guest_active, perf_overflow;
	logic [31:0] guest_cfg_active;
	int err_total, tests_run;
	localparam vsp_perf_ev_type EV_NONE = '{1'b0, 1'b0, 8'h00};
	localparam vsp_perf_ev_type EV_G2H = '{1'b1, 1'b0, 8'h05};
	localparam vsp_perf_ev_type EV_G2H6 = '{1'b1, 1'b0, 8'h06};
	localparam vsp_perf_ev_type EV_H2G = '{1'b0, 1'b1, 8'h05};
	localparam vsp_irq_type IRQ_BASE = '{1'b0, 16'h0001, 8'h00, 1'b0};
	localparam vsp_irq_type IRQ_IDLE = '{1'b0, 16'h0000, 8'h00, 1'b0};
	localparam vsp_irq_type IRQ_BUSY = '{1'b0, 16'h0100, 8'hff, 1'b1};
	localparam vsp_irq_type IRQ_EPL = '{1'b1, 16'h0001, 8'hff, 1'b0};
	localparam vsp_irq_type IRQ_EPLM = '{1'b1, 16'h0000, 8'hfe, 1'b0};
	localparam vsp_irq_type IRQ_DIS = '{1'b0, 16'h0000, 8'h00, 1'b1};

	always #10 core_clk = ~core_clk;

	vsp_top DUT (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
		.virt_implemented(virt_implemented), .sr_req(sr_req),
		.supervisor_priv(supervisor_priv), .sr_rsp(sr_rsp), .perf_ev(perf_ev),
		.irq_state(irq_state), .virt_enable(virt_enable), .guest_active(guest_active),
		.guest_cfg_active(guest_cfg_active), .perf_overflow(perf_overflow));

	vsp_core_model core (.core_clk(core_clk), .sr_req(sr_req), .sr_rsp(sr_rsp),
		.perf_ev(perf_ev), .irq_state(irq_state));

	// ------------------------------------------------------------
	// Checking tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic acc(input logic w, input logic [9:0] sr, input logic [31:0] wd,
		input logic [1:0] fu, input logic [31:0] ed);
		core.access(w, sr, wd, r);
		chk("rsp_valid", 32'h1, {31'h0, r.valid});
		chk("fault_undef", {30'h0, fu}, {30'h0, r.fault, r.undef});
		chk("rdata", ed, r.rdata);
	endtask

	function automatic logic [31:0] cw(input logic [7:0] event_select, input logic he,
		input logic [7:0] ge);
		return {7'h00, ge, he, event_select, 8'h01};
	endfunction

	// Clears the counter, arms the control word, applies the stimulus and reads back.
	task automatic perf(input logic [31:0] ctrl, input logic [7:0] sub,
		input vsp_perf_ev_type ev, input vsp_irq_type irq, input int n,
		input logic [31:0] exp);
		acc(1'b1, VSP_SR_PC_SUB, {24'h0, sub}, 2'b00, 32'h0);
		acc(1'b1, VSP_SR_PC_VALUE, 32'h0, 2'b00, 32'h0);
		acc(1'b1, VSP_SR_PC_CTRL, ctrl, 2'b00, 32'h0);
		core.stim(ev, irq, n);
		acc(1'b0, VSP_SR_PC_VALUE, 32'h0, 2'b00, exp);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	// The sequence needs well under two thousand cycles; ten thousand means a hang.
	initial begin
		#200000;
		err_total++;
		close_out();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		clk_en = 1'b1;
		virt_implemented = 1'b0;
		supervisor_priv = 1'b1;
		err_total = 0;
		tests_run = 0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		acc(1'b0, VSP_SR_VIRT_CFG, 32'h0, 2'b00, 32'h0);
		acc(1'b1, VSP_SR_VIRT_CFG, 32'h1, 2'b00, 32'h0);
		acc(1'b0, VSP_SR_VIRT_CFG, 32'h0, 2'b00, 32'h0);
		acc(1'b0, VSP_SR_GUEST_CFG, 32'h0, 2'b01, 32'h0);
		acc(1'b0, 10'h3ff, 32'h0, 2'b01, 32'h0);
		@(posedge core_clk);
		supervisor_priv <= 1'b0;
		acc(1'b1, VSP_SR_VIRT_CFG, 32'h1, 2'b10, 32'h0);
		acc(1'b0, VSP_SR_STATUS_EXT, 32'h0, 2'b00, 32'h0);
		@(posedge core_clk);
		supervisor_priv <= 1'b1;
		virt_implemented <= 1'b1;
		// Reserved bits are written as ones on purpose to see them read back as zero.
		acc(1'b1, VSP_SR_VIRT_CFG, 32'hffffffff, 2'b00, 32'h0);
		acc(1'b0, VSP_SR_VIRT_CFG, 32'h0, 2'b00, 32'h1);
		chk("virt_enable", 32'h1, {31'h0, virt_enable});
		$display("test access done");
		perf(cw(8'h18, 1'b1, 8'h00), 8'h00, EV_G2H, IRQ_BASE, 1, 32'h1);
		perf(cw(8'h18, 1'b0, 8'hff), 8'h00, EV_G2H, IRQ_BASE, 1, 32'h0);
		perf(cw(8'h19, 1'b0, 8'hff), 8'h00, EV_H2G, IRQ_BASE, 1, 32'h0);
		perf(cw(8'h19, 1'b1, 8'h00), 8'h00, EV_H2G, IRQ_BASE, 1, 32'h1);
		perf(cw(8'h1a, 1'b0, 8'hff), 8'h00, EV_G2H, IRQ_BASE, 1, 32'h0);
		perf(cw(8'h1a, 1'b1, 8'h00), 8'h00, EV_G2H, IRQ_BASE, 1, 32'h1);
		perf(cw(8'h1a, 1'b1, 8'h00), 8'h05, EV_G2H, IRQ_BASE, 1, 32'h1);
		perf(cw(8'h1a, 1'b1, 8'h00), 8'h05, EV_G2H6, IRQ_BASE, 1, 32'h0);
		perf(cw(8'h28, 1'b0, 8'h00), 8'h00, EV_NONE, IRQ_IDLE, 3, 32'h3);
		perf(cw(8'h28, 1'b0, 8'h00), 8'h00, EV_NONE, IRQ_BUSY, 3, 32'h0);
		perf(cw(8'h28, 1'b0, 8'h00), 8'h00, EV_NONE, IRQ_EPL, 3, 32'h3);
		perf(cw(8'h28, 1'b0, 8'h00), 8'h00, EV_NONE, IRQ_EPLM, 3, 32'h0);
		perf(cw(8'h29, 1'b0, 8'h00), 8'h00, EV_NONE, IRQ_DIS, 4, 32'h4);
		perf(cw(8'h29, 1'b0, 8'h00), 8'h00, EV_NONE, IRQ_IDLE, 4, 32'h0);
		perf(cw(8'h28, 1'b0, 8'h00) & 32'hfffffffe, 8'h00, EV_NONE, IRQ_IDLE, 3,
			32'h0);
		// Clock enable low must freeze the counter through an idle stretch that would count.
		acc(1'b1, VSP_SR_PC_VALUE, 32'h0, 2'b00, 32'h0);
		acc(1'b1, VSP_SR_PC_CTRL, cw(8'h28, 1'b0, 8'h00), 2'b00, 32'h0);
		@(posedge core_clk);
		clk_en <= 1'b0;
		core.stim(EV_NONE, IRQ_IDLE, 3);
		clk_en <= 1'b1;
		acc(1'b0, VSP_SR_PC_VALUE, 32'h0, 2'b00, 32'h0);
		$display("test perf done");
		acc(1'b1, VSP_SR_GUEST_CFG, 32'h5a, 2'b00, 32'h0);
		acc(1'b1, VSP_SR_NOTIFY, 32'h33, 2'b00, 32'h0);
		chk("guest_cfg_host", 32'h0, guest_cfg_active);
		acc(1'b1, VSP_SR_PC_VALUE, 32'hffffffff, 2'b00, 32'h0);
		acc(1'b1, VSP_SR_PC_CTRL, cw(8'h18, 1'b0, 8'h04), 2'b00, 32'h0);
		acc(1'b1, VSP_SR_STATUS_EXT, 32'h80000200, 2'b00, 32'h0);
		@(posedge core_clk);
		#1;
		chk("guest_active", 32'h1, {31'h0, guest_active});
		chk("guest_cfg_guest", 32'h5a, guest_cfg_active);
		// Guest mode cannot be left by software here, so the count shows only as a wrap.
		core.stim(EV_G2H, IRQ_BASE, 1);
		repeat (2) @(posedge core_clk);
		#1;
		chk("perf_overflow", 32'h1, {31'h0, perf_overflow});
		acc(1'b1, VSP_SR_VIRT_CFG, 32'h0, 2'b10, 32'h0);
		acc(1'b1, VSP_SR_STATUS_EXT, 32'h0, 2'b10, 32'h0);
		acc(1'b0, VSP_SR_NOTIFY, 32'h0, 2'b00, 32'h33);
		acc(1'b1, VSP_SR_NOTIFY, 32'h0, 2'b10, 32'h0);
		acc(1'b1, VSP_SR_EI_SAVE, 32'h1, 2'b10, 32'h0);
		acc(1'b0, VSP_SR_STATUS_EXT, 32'h0, 2'b00, 32'h80000200);
		$display("test guest done");
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		#1;
		chk("virt_enable_rst", 32'h0, {31'h0, virt_enable});
		chk("guest_active_rst", 32'h0, {31'h0, guest_active});
		$display("test reset done");
		close_out();
	end
endmodule

/* vsp_core_model.sv */
// Core-side model that issues system register accesses and drives event state.
module vsp_core_model
	import vsp_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Register access
	output vsp_pkg::vsp_sr_req_type sr_req,
	input wire vsp_pkg::vsp_sr_rsp_type sr_rsp,
	// Event and interrupt state
	output vsp_pkg::vsp_perf_ev_type perf_ev,
	output vsp_pkg::vsp_irq_type irq_state
);
	import vsp_pkg::*;

	// ------------------------------------------------------------
	// Idle state
	// ------------------------------------------------------------
	// In-service bit set and extended mode off, so no idle event counts here.
	localparam vsp_irq_type IRQ_BASE = '{1'b0, 16'h0001, 8'h00, 1'b0};

	initial begin
		sr_req = '0;
		perf_ev = '0;
		irq_state = IRQ_BASE;
	end

	// ------------------------------------------------------------
	// Access by register number and selection id
	// ------------------------------------------------------------
	// The request is taken on the edge after it is raised, and the registered answer is read just after that same edge.
	task automatic access(input logic w, input logic [9:0] sr, input logic [31:0] wd,
		output vsp_sr_rsp_type rsp);
		@(posedge core_clk);
		sr_req <= '{1'b1, w, sr[9:5], sr[4:0], wd};
		@(posedge core_clk);
		sr_req.valid <= 1'b0;
		sr_req.wdata <= ~wd;
		#1;
		rsp = sr_rsp;
	endtask

	// Holds an event or interrupt state for exactly n sampling edges.
	task automatic stim(input vsp_perf_ev_type ev, input vsp_irq_type irq, input int n);
		@(posedge core_clk);
		perf_ev <= ev;
		irq_state <= irq;
		repeat (n) @(posedge core_clk);
		perf_ev <= '0;
		irq_state <= IRQ_BASE;
	endtask
endmodule

/* vsp_pkg.sv */
// Shared constants and carrier types for the virtualization register bank.
package vsp_pkg;

	// ------------------------------------------------------------
	// System register numbers, written as {register number, selection id}
	// ------------------------------------------------------------
	localparam logic [9:0] VSP_SR_VIRT_CFG = {5'h10, 5'h01};
	localparam logic [9:0] VSP_SR_GUEST_CFG = {5'h11, 5'h01};
	localparam logic [9:0] VSP_SR_STATUS_EXT = {5'h0f, 5'h00};
	localparam logic [9:0] VSP_SR_EI_SAVE = {5'h12, 5'h00};
	localparam logic [9:0] VSP_SR_FE_SAVE = {5'h13, 5'h00};
	localparam logic [9:0] VSP_SR_NOTIFY = {5'h14, 5'h01};
	localparam logic [9:0] VSP_SR_DEBUG = {5'h00, 5'h03};
	localparam logic [9:0] VSP_SR_PC_CTRL = {5'h00, 5'h0e};
	localparam logic [9:0] VSP_SR_PC_VALUE = {5'h01, 5'h0e};
	localparam logic [9:0] VSP_SR_PC_SUB = {5'h02, 5'h0e};

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int VSP_VE_BIT = 0;
	localparam int VSP_GM_BIT = 31;
	localparam int VSP_GUEST_PARTITION_TAG_LSB = 8;
	localparam int VSP_GUEST_PARTITION_TAG_W = 3;
	localparam int VSP_CEN_BIT = 0;
	localparam int VSP_OVF_BIT = 1;
	localparam int VSP_CND_LSB = 8;
	localparam int VSP_CND_W = 8;
	localparam int VSP_HE_BIT = 16;
	localparam int VSP_GE_LSB = 17;
	localparam int VSP_GE_W = 8;
	localparam int VSP_SUB_W = 8;
	localparam logic [31:0] VSP_CTRL_WMASK = 32'h01ffff03;

	// ------------------------------------------------------------
	// Event selections and idle codes
	// ------------------------------------------------------------
	localparam logic [7:0] VSP_EV_G2H_MODE = 8'h18;
	localparam logic [7:0] VSP_EV_H2G_RET = 8'h19;
	localparam logic [7:0] VSP_EV_G2H_HOST = 8'h1a;
	localparam logic [7:0] VSP_EV_NO_IRQ = 8'h28;
	localparam logic [7:0] VSP_EV_IRQ_DIS = 8'h29;
	localparam logic [15:0] VSP_ISP_IDLE = 16'h0000;
	localparam logic [7:0] VSP_IRQ_PRIORITY_MASK_OPEN = 8'hff;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] VSP_RST_WORD = 32'h00000000;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] reg_id;
		logic [4:0] sel_id;
		logic [31:0] wdata;
	} vsp_sr_req_type;

	typedef struct packed {
		logic valid;
		logic fault;
		logic undef;
		logic [31:0] rdata;
	} vsp_sr_rsp_type;

	typedef struct packed {
		logic ext_priority_level_mode;
		logic [15:0] inservice_priority_bits;
		logic [7:0] irq_priority_mask;
		logic irq_disable_flag;
	} vsp_irq_type;

	typedef struct packed {
		logic g2h_instr;
		logic h2g_return;
		logic [7:0] cause;
	} vsp_perf_ev_type;

endpackage

/* vsp_top.sv */
// Virtualization system registers with performance event qualification.
module vsp_top
	import vsp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Feature strap from the core
	input wire logic virt_implemented,
	// System register access from the core
	input wire vsp_pkg::vsp_sr_req_type sr_req,
	input wire logic supervisor_priv,
	output vsp_pkg::vsp_sr_rsp_type sr_rsp,
	// Event and interrupt state from the core
	input wire vsp_pkg::vsp_perf_ev_type perf_ev,
	input wire vsp_pkg::vsp_irq_type irq_state,
	// Control state to the core
	output logic virt_enable,
	output logic guest_active,
	output logic [31:0] guest_cfg_active,
	output logic perf_overflow
);
	import vsp_pkg::*;

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic virt_enable_q;
	logic [31:0] guest_mode_config_q;
	logic [31:0] status_word_ext_q;
	logic [31:0] ei_save_q;
	logic [31:0] fe_save_q;
	logic [31:0] guest_notify_q;
	logic [31:0] host_debug_q;
	logic [31:0] perf_ctrl_q;
	logic [31:0] perf_value_q;
	logic [31:0] perf_sub_q;
	vsp_sr_rsp_type rsp_q;
	logic guest_active_q;
	logic [31:0] guest_cfg_q;

	// ------------------------------------------------------------
	// Access decode and privilege
	// ------------------------------------------------------------
	logic [9:0] sr_num;
	logic in_guest;
	logic hv_priv;
	logic is_open_reg;
	logic is_hidden_reg;
	logic is_known;
	logic acc_undef;
	logic acc_ok;
	logic wr_en;
	logic [31:0] rd_word;

	assign sr_num = {sr_req.reg_id, sr_req.sel_id};
	assign in_guest = virt_enable_q & status_word_ext_q[VSP_GM_BIT];
	assign hv_priv = supervisor_priv & ~in_guest;
	assign is_open_reg = (sr_num == VSP_SR_STATUS_EXT) | (sr_num == VSP_SR_NOTIFY);
	// These read as undefined while virtualization is off; contents are kept.
	assign is_hidden_reg = (sr_num == VSP_SR_GUEST_CFG) | (sr_num == VSP_SR_NOTIFY)
		| (sr_num == VSP_SR_DEBUG);

	always_comb begin
		unique case (sr_num)
			VSP_SR_VIRT_CFG: rd_word = {31'h00000000, virt_enable_q};
			VSP_SR_GUEST_CFG: rd_word = guest_mode_config_q;
			VSP_SR_STATUS_EXT: rd_word = status_word_ext_q;
			VSP_SR_EI_SAVE: rd_word = ei_save_q;
			VSP_SR_FE_SAVE: rd_word = fe_save_q;
			VSP_SR_NOTIFY: rd_word = guest_notify_q;
			VSP_SR_DEBUG: rd_word = host_debug_q;
			VSP_SR_PC_CTRL: rd_word = perf_ctrl_q;
			VSP_SR_PC_VALUE: rd_word = perf_value_q;
			VSP_SR_PC_SUB: rd_word = perf_sub_q;
			default: rd_word = VSP_RST_WORD;
		endcase
	end

	assign is_known = (sr_num == VSP_SR_VIRT_CFG) | (sr_num == VSP_SR_GUEST_CFG)
		| is_open_reg | (sr_num == VSP_SR_EI_SAVE) | (sr_num == VSP_SR_FE_SAVE)
		| (sr_num == VSP_SR_DEBUG) | (sr_num == VSP_SR_PC_CTRL)
		| (sr_num == VSP_SR_PC_VALUE) | (sr_num == VSP_SR_PC_SUB);
	assign acc_undef = ~is_known | (is_hidden_reg & ~virt_enable_q);

	always_comb begin
		if (is_open_reg && !sr_req.write) begin
			acc_ok = 1'b1;
		end else begin
			acc_ok = virt_enable_q ? hv_priv : supervisor_priv;
		end
	end

	assign wr_en = sr_req.valid & sr_req.write & ~acc_undef & acc_ok;

	// ------------------------------------------------------------
	// Access response
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rsp_q <= '0;
		end else if (clk_en) begin
			rsp_q.valid <= sr_req.valid;
			rsp_q.undef <= sr_req.valid & acc_undef;
			rsp_q.fault <= sr_req.valid & ~acc_undef & ~acc_ok;
			rsp_q.rdata <= (sr_req.valid & ~sr_req.write & ~acc_undef & acc_ok)
				? rd_word : VSP_RST_WORD;
		end
	end

	// ------------------------------------------------------------
	// Virtualization control registers
	// ------------------------------------------------------------
	// The enable flips the whole access model, so software must only touch it early.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			virt_enable_q <= 1'b0;
		end else if (clk_en && wr_en && sr_num == VSP_SR_VIRT_CFG) begin
			virt_enable_q <= sr_req.wdata[VSP_VE_BIT] & virt_implemented;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			guest_mode_config_q <= VSP_RST_WORD;
			status_word_ext_q <= VSP_RST_WORD;
			ei_save_q <= VSP_RST_WORD;
			fe_save_q <= VSP_RST_WORD;
			guest_notify_q <= VSP_RST_WORD;
			host_debug_q <= VSP_RST_WORD;
		end else if (clk_en && wr_en) begin
			unique case (sr_num)
				VSP_SR_GUEST_CFG: guest_mode_config_q <= sr_req.wdata;
				VSP_SR_STATUS_EXT: status_word_ext_q <= sr_req.wdata;
				VSP_SR_EI_SAVE: ei_save_q <= sr_req.wdata;
				VSP_SR_FE_SAVE: fe_save_q <= sr_req.wdata;
				VSP_SR_NOTIFY: guest_notify_q <= sr_req.wdata;
				VSP_SR_DEBUG: host_debug_q <= sr_req.wdata;
				default: ;
			endcase
		end
	end

	// Guest configuration steers the core only in guest mode with virtualization on.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			guest_active_q <= 1'b0;
			guest_cfg_q <= VSP_RST_WORD;
		end else if (clk_en) begin
			guest_active_q <= in_guest;
			guest_cfg_q <= in_guest ? guest_mode_config_q : VSP_RST_WORD;
		end
	end

	// ------------------------------------------------------------
	// Event qualification
	// ------------------------------------------------------------
	logic [7:0] ev_sel;
	logic host_en;
	logic [VSP_GUEST_PARTITION_TAG_W-1:0] guest_partition_tag;
	logic guest_en;
	logic sub_match;
	logic no_irq;
	logic ev_raw;
	logic count_hit;

	assign ev_sel = perf_ctrl_q[VSP_CND_LSB +: VSP_CND_W];
	assign host_en = perf_ctrl_q[VSP_HE_BIT];
	assign guest_partition_tag = status_word_ext_q[VSP_GUEST_PARTITION_TAG_LSB +: VSP_GUEST_PARTITION_TAG_W];
	assign guest_en = perf_ctrl_q[VSP_GE_LSB + 32'(guest_partition_tag)];
	// A zero sub-condition means any cause qualifies.
	assign sub_match = (perf_sub_q[VSP_SUB_W-1:0] == 8'h00)
		| (perf_sub_q[VSP_SUB_W-1:0] == perf_ev.cause);

	// Idle follows the in-service bits, or the priority mask in extended mode, as the core maintains them;
	// when auto update is off, or a low priority request leaves them clear, the count drifts.
	assign no_irq = irq_state.ext_priority_level_mode
		? (irq_state.irq_priority_mask == VSP_IRQ_PRIORITY_MASK_OPEN)
		: (irq_state.inservice_priority_bits == VSP_ISP_IDLE);

	always_comb begin
		unique case (ev_sel)
			VSP_EV_G2H_MODE: ev_raw = perf_ev.g2h_instr & sub_match
				& (in_guest ? guest_en : host_en);
			VSP_EV_H2G_RET: ev_raw = perf_ev.h2g_return & host_en;
			VSP_EV_G2H_HOST: ev_raw = perf_ev.g2h_instr & sub_match & host_en;
			VSP_EV_NO_IRQ: ev_raw = no_irq;
			// The disable flag gates the idle condition, level mask included; NMI block is not an input here.
			VSP_EV_IRQ_DIS: ev_raw = no_irq & irq_state.irq_disable_flag;
			default: ev_raw = 1'b0;
		endcase
	end

	assign count_hit = ev_raw & perf_ctrl_q[VSP_CEN_BIT];

	// ------------------------------------------------------------
	// Performance counter
	// ------------------------------------------------------------
	logic wr_ctrl;
	logic wr_value;
	logic wrap;

	assign wr_ctrl = wr_en & (sr_num == VSP_SR_PC_CTRL);
	assign wr_value = wr_en & (sr_num == VSP_SR_PC_VALUE);
	assign wrap = count_hit & (perf_value_q == 32'hffffffff);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			perf_value_q <= VSP_RST_WORD;
		end else if (clk_en) begin
			if (wr_value) begin
				perf_value_q <= sr_req.wdata;
			end else if (count_hit) begin
				perf_value_q <= perf_value_q + 32'h00000001;
			end
		end
	end

	// A wrap in the same cycle as a control write still sets the overflow flag.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			perf_ctrl_q <= VSP_RST_WORD;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				perf_ctrl_q <= sr_req.wdata & VSP_CTRL_WMASK;
			end
			if (wrap && !wr_value) begin
				perf_ctrl_q[VSP_OVF_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			perf_sub_q <= VSP_RST_WORD;
		end else if (clk_en && wr_en && sr_num == VSP_SR_PC_SUB) begin
			perf_sub_q <= sr_req.wdata;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sr_rsp = rsp_q;
	assign virt_enable = virt_enable_q;
	assign guest_active = guest_active_q;
	assign guest_cfg_active = guest_cfg_q;
	assign perf_overflow = perf_ctrl_q[VSP_OVF_BIT];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_cfg_read;
		clk_en && sr_req.valid && !sr_req.write && sr_num == VSP_SR_VIRT_CFG;
	endsequence

	sequence s_guest_swe_write;
		clk_en && sr_req.valid && sr_req.write && sr_num == VSP_SR_STATUS_EXT && in_guest;
	endsequence

	a_guest_g2h_tag: assert property (clk_en && ev_sel == VSP_EV_G2H_MODE && in_guest
		&& perf_ev.g2h_instr && !guest_en |-> !count_hit)
		else $error("guest transition counted without partition enable");

	a_return_host_only: assert property (ev_sel == VSP_EV_H2G_RET && !host_en
		|-> !count_hit)
		else $error("return counted without host enable");

	a_host_class_only: assert property (ev_sel == VSP_EV_G2H_HOST && !host_en
		|-> !count_hit)
		else $error("host class event counted without host enable");

	a_idle_isp: assert property (ev_sel == VSP_EV_NO_IRQ && perf_ctrl_q[VSP_CEN_BIT]
		&& !irq_state.ext_priority_level_mode
		|-> count_hit == (irq_state.inservice_priority_bits == 16'h0000))
		else $error("idle cycle miscounted with in-service bits");

	a_idle_mask: assert property (ev_sel == VSP_EV_NO_IRQ && perf_ctrl_q[VSP_CEN_BIT]
		&& irq_state.ext_priority_level_mode
		|-> count_hit == (irq_state.irq_priority_mask == 8'hff))
		else $error("idle cycle miscounted with priority mask");

	a_disabled_cycle: assert property (ev_sel == VSP_EV_IRQ_DIS
		&& perf_ctrl_q[VSP_CEN_BIT] |-> count_hit == (no_irq && irq_state.irq_disable_flag))
		else $error("disabled cycle miscounted");

	a_count_step: assert property (clk_en && count_hit && !wr_value
		|=> perf_value_q == $past(perf_value_q) + 32'h00000001)
		else $error("counter did not step on event");

	a_count_halt: assert property (clk_en && !perf_ctrl_q[VSP_CEN_BIT] && !wr_value
		|=> $stable(perf_value_q))
		else $error("counter moved while disabled");

	a_cfg_reserved: assert property ((s_cfg_read and acc_ok) |=> sr_rsp.valid
		&& sr_rsp.rdata[31:1] == 31'h00000000 && sr_rsp.rdata[0] == $past(virt_enable_q))
		else $error("config read shows reserved bits or wrong enable");

	a_enable_stuck: assert property (clk_en && !virt_implemented
		&& wr_en && sr_num == VSP_SR_VIRT_CFG |=> !virt_enable_q)
		else $error("enable set without virtualization implemented");

	a_guest_wr_block: assert property (s_guest_swe_write
		|=> sr_rsp.fault && $stable(status_word_ext_q))
		else $error("guest write to status extension not blocked");

	a_hidden_undef: assert property (clk_en && sr_req.valid && !virt_enable_q
		&& sr_num == VSP_SR_GUEST_CFG |=> sr_rsp.undef && sr_rsp.rdata == 32'h00000000
		&& $stable(guest_mode_config_q))
		else $error("guest config not undefined while disabled");

	a_guest_cfg_gate: assert property (clk_en && !in_guest
		|=> guest_cfg_active == 32'h00000000)
		else $error("guest config active outside guest mode");

	a_priv_check: assert property (clk_en && sr_req.valid && virt_enable_q
		&& sr_num == VSP_SR_EI_SAVE && !hv_priv |=> sr_rsp.fault)
		else $error("save register reached without hypervisor privilege");

endmodule
